// file: pkg/vfw_pkg.sv
// constants and carrier types for the video frame timing and window block
// Contract
// (RULE1) count each line in pixel clocks and each frame in lines
// (RULE2) clip out-of-range timing or window settings to their allowed bound
// (RULE3) line length is 10 bits: top two at index 82 [1:0], low at 83
// (RULE4) host writes length minus one; reset 761; lines last setting plus one
// (RULE5) frame length is 10 bits: top two at index 97 [1:0], low at 98
// (RULE6) host writes length minus one; reset 523; frames last setting plus one
// (RULE7) window x start: bit 8 at index 87, low at 88; reset 160, max 320
// (RULE8) window y start: 8 bits at index 90; reset 120, range 0 to 240
// (RULE9) window offsets act only in window-of-interest output mode
// (RULE10) new timing and window values take effect at the next frame boundary
package vfw_pkg;

  // register indices on the configuration port
  localparam logic [7:0] VFW_IDX_LINE_HI = 8'h52;
  localparam logic [7:0] VFW_IDX_LINE_LO = 8'h53;
  localparam logic [7:0] VFW_IDX_XS_HI = 8'h57;
  localparam logic [7:0] VFW_IDX_XS_LO = 8'h58;
  localparam logic [7:0] VFW_IDX_YS = 8'h5a;
  localparam logic [7:0] VFW_IDX_FRAME_HI = 8'h61;
  localparam logic [7:0] VFW_IDX_FRAME_LO = 8'h62;

  // field widths
  localparam int VFW_LEN_W = 10;
  localparam int VFW_XS_W = 9;
  localparam int VFW_YS_W = 8;

  // reset values
  localparam logic [9:0] VFW_LINE_RST = 10'h2f9;
  localparam logic [9:0] VFW_FRAME_RST = 10'h20b;
  localparam logic [8:0] VFW_XS_RST = 9'h0a0;
  localparam logic [7:0] VFW_YS_RST = 8'h78;

  // window bounds
  localparam logic [8:0] VFW_XS_MAX = 9'h140;
  localparam logic [7:0] VFW_YS_MAX = 8'hf0;
  localparam logic [9:0] VFW_WIN_W = 10'h140;
  localparam logic [9:0] VFW_WIN_H = 10'h0f0;

  // timing seen by the companion processor
  typedef struct packed {
    logic [9:0] pix;
    logic [9:0] line;
    logic line_first;
    logic frame_first;
    logic win_on;
  } vfw_video_t;

  // window corner currently applied
  typedef struct packed {
    logic [8:0] x;
    logic [7:0] y;
  } vfw_corner_t;

endpackage

// file: verification/test_vfw_timing.sv
// self-checking bench for the video frame timing and window block
`timescale 1ns/1ns
`default_nettype none
module test_vfw_timing
  import vfw_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_idx = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic woi_mode = 1'b0;
  logic [7:0] reg_rdata;
  vfw_video_t video;
  vfw_corner_t corner;
  logic frame_end;
  logic [10:0] line_clks;
  logic [10:0] frame_lines;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;
  // 20 MHz pixel clock
  always #25 clk = ~clk;
  vfw_timing dut (.clk(clk), .srst(srst), .reg_idx(reg_idx),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .woi_mode(woi_mode), .video(video), .corner(corner),
    .frame_end(frame_end));
  vfw_companion peer (.clk(clk), .srst(srst), .video(video),
    .line_clks(line_clks), .frame_lines(frame_lines));
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // the reset frame alone is 762 x 524 clocks, so the ceiling sits above it
  always @(posedge clk) begin
    cycles++;
    if (cycles == 450000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(negedge clk);
    reg_idx = idx;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd_check(input logic [7:0] idx, input logic [7:0] exp);
    @(negedge clk);
    reg_idx = idx;
    @(negedge clk);
    @(negedge clk);
    check({3'h0, reg_rdata}, {3'h0, exp});
  endtask
  // returns once the frame after the boundary is under way and the one before it measured
  task automatic wait_frame();
    while (frame_end !== 1'b1) @(negedge clk);
    @(negedge clk);
    @(negedge clk);
  endtask
  task automatic test_reset_values();
    rd_check(VFW_IDX_LINE_HI, 8'h02);
    rd_check(VFW_IDX_LINE_LO, 8'hf9);
    rd_check(VFW_IDX_FRAME_HI, 8'h02);
    rd_check(VFW_IDX_FRAME_LO, 8'h0b);
    rd_check(VFW_IDX_XS_HI, 8'h00);
    rd_check(VFW_IDX_XS_LO, 8'ha0);
    rd_check(VFW_IDX_YS, 8'h78);
    check({2'h0, corner.x}, 11'h000);
  endtask
  // out-of-range corner, short timing, all written mid-frame
  task automatic test_new_timing();
    wr(VFW_IDX_LINE_HI, 8'hfc);
    wr(VFW_IDX_LINE_LO, 8'h63);
    wr(VFW_IDX_FRAME_HI, 8'hfc);
    wr(VFW_IDX_FRAME_LO, 8'h09);
    wr(VFW_IDX_XS_HI, 8'h01);
    wr(VFW_IDX_XS_LO, 8'h90);
    wr(VFW_IDX_YS, 8'hfa);
    woi_mode = 1'b1;
    rd_check(VFW_IDX_LINE_HI, 8'h00);
    rd_check(VFW_IDX_XS_LO, 8'h90);
    repeat (1600) @(negedge clk);
    check(line_clks, 11'h2fa);
    check({2'h0, corner.x}, 11'h000);
    wait_frame();
    check(frame_lines, 11'h20c);
    check({2'h0, corner.x}, 11'h140);
    check({3'h0, corner.y}, 11'h0f0);
    wait_frame();
    check(line_clks, 11'h064);
    check(frame_lines, 11'h00a);
  endtask
  task automatic test_woi_select();
    woi_mode = 1'b0;
    wr(VFW_IDX_XS_HI, 8'h00);
    wr(VFW_IDX_XS_LO, 8'h05);
    wr(VFW_IDX_YS, 8'h01);
    wait_frame();
    check({2'h0, corner.x}, 11'h000);
    check({10'h000, video.win_on}, 11'h000);
    woi_mode = 1'b1;
    wait_frame();
    check({2'h0, corner.x}, 11'h005);
    check({3'h0, corner.y}, 11'h001);
    check({10'h000, video.win_on}, 11'h000);
    while (video.line !== 10'h001 || video.pix !== 10'h004) @(negedge clk);
    check({10'h000, video.win_on}, 11'h000);
    @(negedge clk);
    check({10'h000, video.win_on}, 11'h001);
    while (video.line !== 10'h001 || video.pix !== 10'h032) @(negedge clk);
    check({10'h000, video.win_on}, 11'h001);
    // window at the origin must be on by the second pixel of the frame
    wr(VFW_IDX_XS_LO, 8'h00);
    wr(VFW_IDX_YS, 8'h00);
    wait_frame();
    check({10'h000, video.win_on}, 11'h001);
  endtask
  initial begin
    repeat (8) @(negedge clk);
    srst = 1'b0;
    test_reset_values();
    test_new_timing();
    test_woi_select();
    complete_run();
  end
endmodule
`default_nettype wire

// file: verification/vfw_companion.sv
// companion processor model: measures line and frame length as received
`timescale 1ns/1ns
`default_nettype none
module vfw_companion
  import vfw_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // timing from the sensor
  input wire vfw_video_t video,
  // last complete line in clocks, last complete frame in lines
  output logic [10:0] line_clks,
  output logic [10:0] frame_lines
);
  logic [10:0] clk_cnt_r;
  logic [10:0] line_cnt_r;
  // the first figures after reset are partial, so the bench reads later ones
  always_ff @(posedge clk) begin
    if (srst) begin
      clk_cnt_r <= 11'h000;
      line_cnt_r <= 11'h000;
    end else if (video.line_first) begin
      clk_cnt_r <= 11'h001;
      line_clks <= clk_cnt_r;
      if (video.frame_first) begin
        frame_lines <= line_cnt_r;
        line_cnt_r <= 11'h001;
      end else begin
        line_cnt_r <= line_cnt_r + 11'h001;
      end
    end else begin
      clk_cnt_r <= clk_cnt_r + 11'h001;
    end
  end
endmodule
`default_nettype wire

// file: verilog/vfw_timing.sv
// video line/frame timing generator with window-of-interest placement
`timescale 1ns/1ns
`default_nettype none
module vfw_timing
  import vfw_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // configuration register port
  input wire logic [7:0] reg_idx,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // output mode select from the output format logic
  input wire logic woi_mode,
  // timing toward the companion processor
  output vfw_video_t video,
  output vfw_corner_t corner,
  output logic frame_end
);

  // programmed values as written by the host
  logic [9:0] line_len_r;
  logic [9:0] frame_len_r;
  logic [8:0] xs_r;
  logic [7:0] ys_r;
  // values in use for the current frame
  logic [9:0] line_act_r;
  logic [9:0] frame_act_r;
  logic [8:0] xs_act_r;
  logic [7:0] ys_act_r;
  logic woi_act_r;
  // counters and flags
  logic [9:0] h_r;
  logic [9:0] v_r;
  logic [9:0] h_nxt;
  logic [9:0] v_nxt;
  logic line_end;
  logic win_r;
  logic win_nxt;
  logic [8:0] xs_clip;
  logic [7:0] ys_clip;
  // window settings that govern the pixel about to be shown
  logic woi_use;
  logic [8:0] xs_use;
  logic [7:0] ys_use;

  // host writes: split 10-bit fields over two indices
  always_ff @(posedge clk) begin
    if (srst) begin
      line_len_r <= VFW_LINE_RST; // RULE4
      frame_len_r <= VFW_FRAME_RST; // RULE6
      xs_r <= VFW_XS_RST; // RULE7
      ys_r <= VFW_YS_RST; // RULE8
    end else if (reg_wr) begin
      unique case (reg_idx)
        VFW_IDX_LINE_HI: line_len_r[9:8] <= reg_wdata[1:0]; // RULE3
        VFW_IDX_LINE_LO: line_len_r[7:0] <= reg_wdata; // RULE3
        VFW_IDX_FRAME_HI: frame_len_r[9:8] <= reg_wdata[1:0]; // RULE5
        VFW_IDX_FRAME_LO: frame_len_r[7:0] <= reg_wdata; // RULE5
        VFW_IDX_XS_HI: xs_r[8] <= reg_wdata[0]; // RULE7
        VFW_IDX_XS_LO: xs_r[7:0] <= reg_wdata; // RULE7
        VFW_IDX_YS: ys_r <= reg_wdata; // RULE8
        default: ;
      endcase
    end
  end

  // readback shows the stored setting, not the clipped one, so the host
  // sees what it wrote; unused upper bits read as zero
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else begin
      unique case (reg_idx)
        VFW_IDX_LINE_HI: reg_rdata <= {6'h00, line_len_r[9:8]};
        VFW_IDX_LINE_LO: reg_rdata <= line_len_r[7:0];
        VFW_IDX_FRAME_HI: reg_rdata <= {6'h00, frame_len_r[9:8]};
        VFW_IDX_FRAME_LO: reg_rdata <= frame_len_r[7:0];
        VFW_IDX_XS_HI: reg_rdata <= {7'h00, xs_r[8]};
        VFW_IDX_XS_LO: reg_rdata <= xs_r[7:0];
        VFW_IDX_YS: reg_rdata <= ys_r;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // clip window corner; 10-bit lengths cannot exceed 1023 by construction
  assign xs_clip = (xs_r > VFW_XS_MAX) ? VFW_XS_MAX : xs_r; // RULE2
  assign ys_clip = (ys_r > VFW_YS_MAX) ? VFW_YS_MAX : ys_r; // RULE2

  // end of line and frame
  assign line_end = (h_r == line_act_r); // RULE1
  assign frame_end = line_end && (v_r == frame_act_r); // RULE1

  // settings applied only at frame wrap to avoid frames of mixed timing
  always_ff @(posedge clk) begin
    if (srst) begin
      line_act_r <= VFW_LINE_RST;
      frame_act_r <= VFW_FRAME_RST;
      xs_act_r <= VFW_XS_RST;
      ys_act_r <= VFW_YS_RST;
      woi_act_r <= 1'b0;
    end else if (frame_end) begin
      line_act_r <= line_len_r; // RULE10
      frame_act_r <= frame_len_r; // RULE10
      xs_act_r <= xs_clip; // RULE10
      ys_act_r <= ys_clip; // RULE10
      woi_act_r <= woi_mode; // RULE9
    end
  end

  // next counter values: a line lasts setting plus one clocks
  always_comb begin
    h_nxt = line_end ? 10'h000 : h_r + 10'h001; // RULE4
    v_nxt = v_r;
    if (frame_end) begin
      v_nxt = 10'h000; // RULE6
    end else if (line_end) begin
      v_nxt = v_r + 10'h001; // RULE1
    end
  end

  // pixel and line counters
  always_ff @(posedge clk) begin
    if (srst) begin
      h_r <= 10'h000;
      v_r <= 10'h000;
    end else begin
      h_r <= h_nxt; // RULE1
      v_r <= v_nxt; // RULE1
    end
  end

  // at the frame wrap the flag is judged with the values about to be
  // applied, so a window placed at the origin shows from its first pixel
  assign woi_use = frame_end ? woi_mode : woi_act_r; // RULE9
  assign xs_use = frame_end ? xs_clip : xs_act_r; // RULE10
  assign ys_use = frame_end ? ys_clip : ys_act_r; // RULE10

  // window flag follows the counters; offsets ignored outside woi mode.
  // mode takes effect with the new frame so a window is never half drawn
  always_comb begin
    win_nxt = 1'b0;
    if (woi_use) begin
      win_nxt = (h_nxt >= {1'b0, xs_use}) &&
                (h_nxt < {1'b0, xs_use} + VFW_WIN_W) &&
                (v_nxt >= {2'b00, ys_use}) &&
                (v_nxt < {2'b00, ys_use} + VFW_WIN_H); // RULE9
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      win_r <= 1'b0;
    end else begin
      win_r <= win_nxt; // RULE9
    end
  end

  // outputs: pix, line and win_on straight from flip-flops; first flags and corner decoded from them
  assign video.pix = h_r;
  assign video.line = v_r;
  assign video.line_first = (h_r == 10'h000);
  assign video.frame_first = (h_r == 10'h000) && (v_r == 10'h000);
  assign video.win_on = win_r;
  assign corner.x = woi_act_r ? xs_act_r : 9'h000; // RULE9
  assign corner.y = woi_act_r ? ys_act_r : 8'h00; // RULE9

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_line_wrap;
    line_end ##1 (h_r == 10'h000);
  endsequence

  sequence s_frame_wrap;
    frame_end ##1 (v_r == 10'h000 && h_r == 10'h000);
  endsequence

  h_wrap_a: assert property (line_end |-> s_line_wrap) // RULE1
    else $error("pixel count did not wrap at line end");
  h_step_a: assert property (!line_end // RULE1
      |=> h_r == $past(h_r) + 10'h001)
    else $error("pixel count did not advance");
  v_step_a: assert property (line_end && !frame_end // RULE1
      |=> v_r == $past(v_r) + 10'h001)
    else $error("line count did not advance at line end");
  v_wrap_a: assert property (frame_end |-> s_frame_wrap) // RULE6
    else $error("line count did not wrap at frame end");
  corner_clip_a: assert property (xs_act_r <= VFW_XS_MAX // RULE2
      && ys_act_r <= VFW_YS_MAX)
    else $error("window corner beyond its bound");
  line_rst_a: assert property (@(posedge clk) disable iff (1'b0) // RULE4
      srst |=> line_act_r == 10'h2f9 && line_len_r == 10'h2f9)
    else $error("line length reset value wrong");
  frame_rst_a: assert property (@(posedge clk) disable iff (1'b0) // RULE6
      srst |=> frame_act_r == 10'h20b && frame_len_r == 10'h20b)
    else $error("frame length reset value wrong");
  corner_rst_a: assert property (@(posedge clk) // RULE7 RULE8
      disable iff (1'b0) srst |=> xs_r == 9'h0a0 && ys_r == 8'h78)
    else $error("window corner reset value wrong");
  line_lo_a: assert property (reg_wr && reg_idx == 8'h53 // RULE3
      |=> line_len_r[7:0] == $past(reg_wdata))
    else $error("line length low byte not stored");
  frame_hi_a: assert property (reg_wr && reg_idx == 8'h61 // RULE5
      |=> frame_len_r[9:8] == $past(reg_wdata[1:0]))
    else $error("frame length high bits not stored");
  x_hi_a: assert property (reg_wr && reg_idx == 8'h57 // RULE7
      |=> xs_r[8] == $past(reg_wdata[0]))
    else $error("window x start high bit not stored");
  y_store_a: assert property (reg_wr && reg_idx == 8'h5a // RULE8
      |=> ys_r == $past(reg_wdata))
    else $error("window y start not stored");
  woi_gate_a: assert property (!woi_act_r // RULE9
      |-> !win_r && corner.x == 9'h000)
    else $error("window active outside woi mode");
  win_origin_a: assert property (frame_end && woi_mode // RULE9
      && xs_clip == 9'h000 && ys_clip == 8'h00 |=> win_r)
    else $error("window at origin missed its first pixel");
  frame_hold_a: assert property (!frame_end // RULE10
      |=> $stable(line_act_r) && $stable(frame_act_r))
    else $error("timing changed inside a frame");
  frame_load_a: assert property (frame_end // RULE10
      |=> line_act_r == $past(line_len_r))
    else $error("new line length not applied at frame end");

endmodule
`default_nettype wire
